//--- rtl/scc_clock_regs.svh
// Purpose: Register offsets, field positions and reset values
// Assumes: 15-bit register address on the configuration serial port
// Notes: Edge position status is a read-only byte triple
`ifndef SCC_CLOCK_REGS_SVH
`define SCC_CLOCK_REGS_SVH

`define SCC_ADDR_USER_CFG 15'h0010
`define SCC_ADDR_SYSREF_CTRL 15'h0029
`define SCC_ADDR_CLKIN_CTRL 15'h002A
`define SCC_ADDR_TUNING 15'h002B
`define SCC_ADDR_POS_B0 15'h002C
`define SCC_ADDR_POS_B1 15'h002D
`define SCC_ADDR_POS_B2 15'h002E

`define SCC_RST_USER_CFG 8'h00
`define SCC_RST_SYSREF_CTRL 8'h00
`define SCC_RST_CLKIN_CTRL 8'h00
`define SCC_RST_TUNING 8'h11

`define SCC_BIT_ADDR_HOLD 0
`define SCC_BIT_PROC_EN 6
`define SCC_BIT_RECV_EN 5
`define SCC_BIT_FINE_SCALE 4
`define SCC_SEL_HI 3
`define SCC_SEL_LO 0
`define SCC_BIT_AS_TSTAMP 3
`define SCC_BIT_DEVCLK_PECL 2
`define SCC_BIT_SYSREF_PECL 1
`define SCC_BIT_POL_FLIP 0
`define SCC_BIT_FB_GAIN 4
`define SCC_BIT_NOISE_FILT 2
`define SCC_DLY_HI 1
`define SCC_DLY_LO 0

`define SCC_INSTR_LAST 5'h0F
`define SCC_BYTE_LAST 3'h7
`define SCC_BIT_RW 15

`endif

//--- rtl/scc_pkg.sv
// Purpose: Types shared by the clock configuration register bank
// Assumes: Nothing beyond the register header
// Notes: Gray-coded serial port states
package scc_pkg;

  typedef enum logic [1:0]
  {
    scc_idle = 2'h0,
    scc_cmd = 2'h1,
    scc_data = 2'h3
  } scc_state_t;

  typedef struct packed
  {
    logic sysref_processor_enable;
    logic sysref_receiver_enable;
    logic sysref_window_fine_scale;
    logic [3:0] sysref_delay_choice;
    logic sysref_as_timestamp;
    logic device_clock_dc_pecl_mode;
    logic sysref_dc_pecl_mode;
    logic sysref_polarity_flip;
    logic feedback_gain_high;
    logic analog_supply_noise_filter;
    logic [1:0] sample_clock_delay_select;
  } scc_clk_cfg_t;

endpackage

//--- rtl/scc_edge_detect.sv
// Purpose: Registers a sampled input and flags its edges
// Assumes: Input is synchronous to ref_clk
// Notes: Edge flags are combinational against the held copy
`timescale 1ns/100ps
module scc_edge_detect
#(
  parameter int WIDTH = 1
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] hold_reg;
  logic [WIDTH-1:0] hold_next;

  generate
    if (WIDTH < 1)
    begin : g_chk
      $error("scc_edge_detect: WIDTH must be at least 1");
    end
  endgenerate

  always_comb
  begin
    hold_next = ce ? d : hold_reg;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      hold_reg <= '0;
    else
      hold_reg <= hold_next;
  end

  assign q = hold_reg;
  assign rise = d & ~hold_reg;
  assign fall = ~d & hold_reg;

endmodule

//--- rtl/scc_clock_config_regs.sv
// Purpose: Clock and SYSREF configuration bank behind the serial port
// Assumes: Serial clock at most a quarter of ref_clk; pins synchronous
// Notes: Frame is 16 instruction bits (read flag, address) then bytes
//
// Contract
// - Unfrozen streaming steps address per direction input
// - Frozen address stays fixed while streaming
// - Processor enable gates SYSREF events
// - Receiver enable gates SYSREF input, off at reset
// - Fine scale bit selects smaller window steps
// - Delay choice field picks SYSREF capture tap
// - Timestamp bit plus enable puts SYSREF on LSB
// - Bits two and one select PECL modes
// - Polarity bit inverts SYSREF for alignment
// - Feedback gain bit resets to high gain
// - Bit two turns on supply noise filter
// - Sample delay is one-hot, resets to one
// - Edge position status readable as 24 bits
`timescale 1ns/100ps
`include "scc_clock_regs.svh"
module scc_clock_config_regs
#(
  parameter int DELAY_TAPS = 16
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic spi_csb_n,
  input wire logic spi_sclk,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic address_descend,
  input wire logic sysref_in,
  input wire logic [23:0] sysref_edge_position,
  input wire logic timestamp_output_enable,
  input wire logic sample_lsb_in,
  output logic sample_lsb_out,
  output logic sysref_event,
  output logic sysref_aligned,
  output scc_pkg::scc_clk_cfg_t clk_cfg
);

  generate
    if (DELAY_TAPS != 16)
    begin : g_chk
      $error("DELAY_TAPS must be 16 to match the 4-bit choice field");
    end
  endgenerate

  // ==========================================================
  // Serial port
  scc_pkg::scc_state_t state_reg, state_next;
  logic [4:0] bit_reg, bit_next;
  logic [15:0] shift_reg, shift_next;
  logic [14:0] addr_reg, addr_next;
  logic rw_reg, rw_next;
  logic [7:0] tx_reg, tx_next;
  logic sdo_reg, sdo_next;
  logic oe_reg, oe_next;
  logic [7:0] user_reg, user_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] clkin_reg, clkin_next;
  logic [7:0] tune_reg, tune_next;
  logic sclk_rise, sclk_fall;
  logic wr_fire;
  logic [15:0] instr;
  logic [7:0] wr_byte;
  logic [14:0] addr_step;

  scc_edge_detect #(.WIDTH(1)) u_sclk_edge
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .ce(ce),
    .d(spi_sclk),
    .q(),
    .rise(sclk_rise),
    .fall(sclk_fall)
  );

  function automatic logic [7:0] read_mux(input logic [14:0] a,
    input logic [7:0] u, input logic [7:0] c, input logic [7:0] k,
    input logic [7:0] t, input logic [23:0] p);
    logic [7:0] r;
    case (a)
      `SCC_ADDR_USER_CFG: r = u;
      `SCC_ADDR_SYSREF_CTRL: r = c;
      `SCC_ADDR_CLKIN_CTRL: r = k;
      `SCC_ADDR_TUNING: r = t;
      `SCC_ADDR_POS_B0: r = p[7:0];
      `SCC_ADDR_POS_B1: r = p[15:8];
      `SCC_ADDR_POS_B2: r = p[23:16];
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  assign instr = {shift_reg[14:0], spi_sdi};
  assign wr_byte = {shift_reg[6:0], spi_sdi};
  assign wr_fire = ce && !spi_csb_n && state_reg == scc_pkg::scc_data &&
    sclk_rise && bit_reg[2:0] == `SCC_BYTE_LAST && !rw_reg;

  always_comb
  begin
    if (user_reg[`SCC_BIT_ADDR_HOLD])
      addr_step = addr_reg;
    else if (address_descend)
      addr_step = addr_reg - 15'h0001;
    else
      addr_step = addr_reg + 15'h0001;
  end

  always_comb
  begin
    state_next = state_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    addr_next = addr_reg;
    rw_next = rw_reg;
    tx_next = tx_reg;
    sdo_next = sdo_reg;
    user_next = user_reg;
    ctrl_next = ctrl_reg;
    clkin_next = clkin_reg;
    tune_next = tune_reg;
    if (spi_csb_n)
    begin
      state_next = scc_pkg::scc_idle;
      bit_next = 5'h00;
    end
    else
    begin
      case (state_reg)
        scc_pkg::scc_idle,
        scc_pkg::scc_cmd:
        begin
          state_next = scc_pkg::scc_cmd;
          if (sclk_rise)
          begin
            shift_next = instr;
            bit_next = bit_reg + 5'h01;
            if (bit_reg == `SCC_INSTR_LAST)
            begin
              rw_next = instr[`SCC_BIT_RW];
              addr_next = instr[14:0];
              tx_next = read_mux(instr[14:0], user_reg, ctrl_reg,
                clkin_reg, tune_reg, sysref_edge_position);
              state_next = scc_pkg::scc_data;
              bit_next = 5'h00;
            end
          end
        end
        scc_pkg::scc_data:
        begin
          if (sclk_rise)
          begin
            shift_next = instr;
            bit_next = {2'h0, bit_reg[2:0] + 3'h1};
            if (bit_reg[2:0] == `SCC_BYTE_LAST)
            begin
              addr_next = addr_step;
              tx_next = read_mux(addr_step, user_reg, ctrl_reg,
                clkin_reg, tune_reg, sysref_edge_position);
              bit_next = 5'h00;
            end
          end
          if (sclk_fall && rw_reg)
            sdo_next = tx_reg[~bit_reg[2:0]];
        end
        default:
        begin
          state_next = scc_pkg::scc_idle;
          bit_next = 5'h00;
        end
      endcase
    end
    // Whole bytes stored, reserved bits included
    if (wr_fire)
    begin
      case (addr_reg)
        `SCC_ADDR_USER_CFG: user_next = wr_byte;
        `SCC_ADDR_SYSREF_CTRL: ctrl_next = wr_byte;
        `SCC_ADDR_CLKIN_CTRL: clkin_next = wr_byte;
        `SCC_ADDR_TUNING: tune_next = wr_byte;
        default: user_next = user_reg;
      endcase
    end
    oe_next = state_next == scc_pkg::scc_data && rw_next && !spi_csb_n;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= scc_pkg::scc_idle;
      bit_reg <= 5'h00;
      shift_reg <= 16'h0000;
      addr_reg <= 15'h0000;
      rw_reg <= 1'h0;
      tx_reg <= 8'h00;
      sdo_reg <= 1'h0;
      oe_reg <= 1'h0;
      user_reg <= `SCC_RST_USER_CFG;
      ctrl_reg <= `SCC_RST_SYSREF_CTRL;
      clkin_reg <= `SCC_RST_CLKIN_CTRL;
      tune_reg <= `SCC_RST_TUNING;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      addr_reg <= addr_next;
      rw_reg <= rw_next;
      tx_reg <= tx_next;
      sdo_reg <= sdo_next;
      oe_reg <= oe_next;
      user_reg <= user_next;
      ctrl_reg <= ctrl_next;
      clkin_reg <= clkin_next;
      tune_reg <= tune_next;
    end
  end

  assign spi_sdo = sdo_reg;
  assign spi_sdo_oe = oe_reg;

  // ==========================================================
  // Configuration outputs
  always_comb
  begin
    clk_cfg.sysref_processor_enable = ctrl_reg[`SCC_BIT_PROC_EN];
    clk_cfg.sysref_receiver_enable = ctrl_reg[`SCC_BIT_RECV_EN];
    clk_cfg.sysref_window_fine_scale = ctrl_reg[`SCC_BIT_FINE_SCALE];
    clk_cfg.sysref_delay_choice = ctrl_reg[`SCC_SEL_HI:`SCC_SEL_LO];
    clk_cfg.sysref_as_timestamp = clkin_reg[`SCC_BIT_AS_TSTAMP];
    clk_cfg.device_clock_dc_pecl_mode = clkin_reg[`SCC_BIT_DEVCLK_PECL];
    clk_cfg.sysref_dc_pecl_mode = clkin_reg[`SCC_BIT_SYSREF_PECL];
    clk_cfg.sysref_polarity_flip = clkin_reg[`SCC_BIT_POL_FLIP];
    clk_cfg.feedback_gain_high = tune_reg[`SCC_BIT_FB_GAIN];
    clk_cfg.analog_supply_noise_filter = tune_reg[`SCC_BIT_NOISE_FILT];
    clk_cfg.sample_clock_delay_select =
      tune_reg[`SCC_DLY_HI:`SCC_DLY_LO];
  end

  // ==========================================================
  // SYSREF path
  logic [DELAY_TAPS-1:0] line_reg, line_next;
  logic event_reg, event_next;
  logic lsb_reg, lsb_next;
  logic sysref_rx;
  logic tap_rise;

  assign sysref_rx = clk_cfg.sysref_receiver_enable &
    (sysref_in ^ clk_cfg.sysref_polarity_flip);
  assign sysref_aligned = line_reg[clk_cfg.sysref_delay_choice];

  scc_edge_detect #(.WIDTH(1)) u_tap_edge
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .ce(ce),
    .d(sysref_aligned),
    .q(),
    .rise(tap_rise),
    .fall()
  );

  always_comb
  begin
    line_next = {line_reg[DELAY_TAPS-2:0], sysref_rx};
    event_next = clk_cfg.sysref_processor_enable & tap_rise;
    if (clk_cfg.sysref_as_timestamp && timestamp_output_enable)
      lsb_next = sysref_rx;
    else
      lsb_next = sample_lsb_in;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      line_reg <= '0;
      event_reg <= 1'h0;
      lsb_reg <= 1'h0;
    end
    else if (ce)
    begin
      line_reg <= line_next;
      event_reg <= event_next;
      lsb_reg <= lsb_next;
    end
  end

  assign sysref_event = event_reg;
  assign sample_lsb_out = lsb_reg;

  // ==========================================================
  // Checks
  sequence byte_done_s(logic [14:0] a);
    wr_fire && addr_reg == a;
  endsequence

  hold_addr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_fire && user_reg[`SCC_BIT_ADDR_HOLD] |=> addr_reg == $past(addr_reg))
    else $error("address moved while frozen");
  step_addr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_fire && !user_reg[`SCC_BIT_ADDR_HOLD] |=>
      addr_reg == ($past(address_descend) ?
      $past(addr_reg) - 15'h0001 : $past(addr_reg) + 15'h0001))
    else $error("address did not step");
  proc_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(sysref_event) |-> $past(ctrl_reg[`SCC_BIT_PROC_EN]))
    else $error("event while processor off");
  rx_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ce && !ctrl_reg[`SCC_BIT_RECV_EN] |=> !line_reg[0])
    else $error("SYSREF passed with receiver off");
  invert_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ce && ctrl_reg[`SCC_BIT_RECV_EN] && clkin_reg[`SCC_BIT_POL_FLIP] |=>
      line_reg[0] == !$past(sysref_in))
    else $error("SYSREF not inverted");
  tstamp_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ce && clkin_reg[`SCC_BIT_AS_TSTAMP] && timestamp_output_enable |=>
      sample_lsb_out == $past(sysref_rx))
    else $error("timestamp not on sample LSB");
  pecl_wr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    byte_done_s(`SCC_ADDR_CLKIN_CTRL) |=>
      clk_cfg.device_clock_dc_pecl_mode ==
        $past(wr_byte[`SCC_BIT_DEVCLK_PECL]) &&
      clk_cfg.sysref_dc_pecl_mode == $past(wr_byte[`SCC_BIT_SYSREF_PECL]))
    else $error("PECL mode bits not written");
  rsvd_wr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    byte_done_s(`SCC_ADDR_USER_CFG) |=> user_reg == $past(wr_byte))
    else $error("user config byte not stored");
  tune_rst_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !$past(reset_n) |-> tune_reg == `SCC_RST_TUNING &&
      ctrl_reg == `SCC_RST_SYSREF_CTRL && user_reg == `SCC_RST_USER_CFG &&
      clkin_reg == `SCC_RST_CLKIN_CTRL)
    else $error("reset values wrong");
  pos_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ce && !spi_csb_n && state_reg != scc_pkg::scc_data && sclk_rise &&
      bit_reg == `SCC_INSTR_LAST && instr[14:0] == `SCC_ADDR_POS_B1 |=>
      tx_reg == $past(sysref_edge_position[15:8]))
    else $error("edge position byte not loaded");

endmodule

//--- test/scc_host_model.sv
// Purpose: Host controller model on the configuration serial port
// Assumes: All pins change just after a ref_clk rising edge
// Notes: Serial clock low 3 cycles, high 2; idle between frames
`timescale 1ns/100ps
module scc_host_model
(
  input wire logic ref_clk,
  output logic spi_csb_n,
  output logic spi_sclk,
  output logic spi_sdi,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe
);
  initial
  begin
    spi_csb_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi = 1'b0;
  end

  // ==========================================
  // Frame: instruction then n bytes, MSB first
  task automatic xfer(input logic rd, input logic [14:0] addr,
    input int n, input logic [31:0] wd, output logic [31:0] got,
    output logic oe_ok);
    logic [15:0] instr;
    logic b;
    instr = {rd, addr};
    got = 32'h0;
    oe_ok = 1'b1;
    @(posedge ref_clk);
    spi_csb_n <= 1'b0;
    for (int i = 0; i < 16 + 8 * n; i++)
    begin
      b = (i < 16) ? instr[15 - i] : wd[31 - (i - 16)];
      @(posedge ref_clk);
      spi_sclk <= 1'b0;
      spi_sdi <= b;
      repeat (3) @(posedge ref_clk);
      if (i >= 16)
        got[31 - (i - 16)] = spi_sdo;
      // Enable stands through the data phase of reads only
      if (spi_sdo_oe !== (rd && i >= 16))
        oe_ok = 1'b0;
      spi_sclk <= 1'b1;
      @(posedge ref_clk);
    end
    @(posedge ref_clk);
    spi_sclk <= 1'b0;
    spi_csb_n <= 1'b1;
    // Released data line must not keep the last bit
    spi_sdi <= ~spi_sdi;
    repeat (2) @(posedge ref_clk);
    if (spi_sdo_oe !== 1'b0)
      oe_ok = 1'b0;
  endtask
endmodule

//--- test/testbench.sv
// Purpose: Self-checking bench for the clock configuration bank
// Assumes: Host model drives the serial port
// Notes: Register contents are modelled in an associative array
`timescale 1ns/100ps
`include "scc_clock_regs.svh"
module testbench;
  logic ref_clk, reset_n, ce, spi_csb_n, spi_sclk, spi_sdi;
  logic spi_sdo, spi_sdo_oe, address_descend, sysref_in;
  logic [23:0] sysref_edge_position;
  logic timestamp_output_enable, sample_lsb_in, sample_lsb_out;
  logic sysref_event, sysref_aligned;
  scc_pkg::scc_clk_cfg_t clk_cfg;
  logic [7:0] mdl[int];
  int miscompares, n_compared, lat0, lat, cnt;
  int addrs[8] = '{`SCC_ADDR_USER_CFG, `SCC_ADDR_SYSREF_CTRL,
    `SCC_ADDR_CLKIN_CTRL, `SCC_ADDR_TUNING, 15'h0011,
    `SCC_ADDR_POS_B0, `SCC_ADDR_POS_B1, `SCC_ADDR_POS_B2};

  scc_clock_config_regs #(.DELAY_TAPS(16)) uut
  (
    .ref_clk(ref_clk), .reset_n(reset_n), .ce(ce),
    .spi_csb_n(spi_csb_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .address_descend(address_descend), .sysref_in(sysref_in),
    .sysref_edge_position(sysref_edge_position),
    .timestamp_output_enable(timestamp_output_enable),
    .sample_lsb_in(sample_lsb_in), .sample_lsb_out(sample_lsb_out),
    .sysref_event(sysref_event), .sysref_aligned(sysref_aligned),
    .clk_cfg(clk_cfg)
  );

  scc_host_model host
  (
    .ref_clk(ref_clk), .spi_csb_n(spi_csb_n), .spi_sclk(spi_sclk),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ==========================================
  // Checking and register access
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [7:0] mread(input int a);
    if (a >= `SCC_ADDR_POS_B0 && a <= `SCC_ADDR_POS_B2)
      return sysref_edge_position[8 * (a - `SCC_ADDR_POS_B0) +: 8];
    return mdl.exists(a) ? mdl[a] : 8'h00;
  endfunction

  task automatic access(input logic rdf, input int a, input int n,
    input logic [31:0] wd);
    logic [31:0] got;
    logic oe_ok;
    host.xfer(rdf, a[14:0], n, wd, got, oe_ok);
    check(oe_ok, 1'b1, "sdo enable");
    for (int i = 0; i < n; i++)
    begin
      if (rdf)
        check(got[31 - 8 * i -: 8], mread(a), "read byte");
      else if (mdl.exists(a))
        mdl[a] = wd[31 - 8 * i -: 8];
      if (!mdl[`SCC_ADDR_USER_CFG][0])
        a = address_descend ? a - 1 : a + 1;
    end
  endtask

  task automatic wr(input int a, input logic [7:0] d);
    access(1'b0, a, 1, {d, 24'h0});
  endtask

  task automatic check_cfg();
    logic [7:0] c, k, t;
    c = mdl[`SCC_ADDR_SYSREF_CTRL];
    k = mdl[`SCC_ADDR_CLKIN_CTRL];
    t = mdl[`SCC_ADDR_TUNING];
    check(clk_cfg, {c[6:0], k[3:0], t[4], t[2], t[1:0]}, "cfg");
  endtask

  // Pulse SYSREF, count events and note the first one's latency
  task automatic pulse(output int l, output int c);
    l = -1;
    c = 0;
    @(posedge ref_clk);
    sysref_in <= 1'b1;
    for (int i = 1; i <= 40; i++)
    begin
      @(posedge ref_clk);
      if (i == 4)
        sysref_in <= 1'b0;
      if (sysref_event !== 1'b0)
      begin
        c++;
        if (l < 0)
          l = i;
      end
    end
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    logic [7:0] d;
    reset_n = 1'b0;
    ce = 1'b1;
    address_descend = 1'b0;
    sysref_in = 1'b0;
    timestamp_output_enable = 1'b0;
    sample_lsb_in = 1'b0;
    miscompares = 0;
    n_compared = 0;
    mdl[`SCC_ADDR_USER_CFG] = `SCC_RST_USER_CFG;
    mdl[`SCC_ADDR_SYSREF_CTRL] = `SCC_RST_SYSREF_CTRL;
    mdl[`SCC_ADDR_CLKIN_CTRL] = `SCC_RST_CLKIN_CTRL;
    mdl[`SCC_ADDR_TUNING] = `SCC_RST_TUNING;
    sysref_edge_position = 24'($urandom(32'h8738));
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    sysref_edge_position <= 24'($urandom());
    check_cfg();
    foreach (addrs[i])
      access(1'b1, addrs[i], 1, 32'h0);
    for (int r = 0; r < 12; r++)
    begin
      d = 8'($urandom());
      if (r % 4 == 0)
        d[0] = 1'b0;
      if (r % 4 == 1)
        d[6] = 1'b0;
      if (r % 4 == 3)
        d[1:0] = d[0] ? 2'h1 : 2'h2;
      wr(addrs[r % 4], d);
      access(1'b1, addrs[r % 4], 1, 32'h0);
      check_cfg();
    end
    access(1'b0, `SCC_ADDR_SYSREF_CTRL, 3, 32'h2A059200);
    access(1'b1, `SCC_ADDR_SYSREF_CTRL, 3, 32'h0);
    check_cfg();
    address_descend <= 1'b1;
    access(1'b1, `SCC_ADDR_TUNING, 4, 32'h0);
    address_descend <= 1'b0;
    wr(`SCC_ADDR_USER_CFG, 8'h01);
    access(1'b0, `SCC_ADDR_CLKIN_CTRL, 3, 32'h030C0900);
    access(1'b1, `SCC_ADDR_CLKIN_CTRL, 2, 32'h0);
    wr(`SCC_ADDR_USER_CFG, 8'h00);
    wr(`SCC_ADDR_POS_B1, 8'hA5);
    access(1'b1, `SCC_ADDR_POS_B0, 3, 32'h0);
    wr(`SCC_ADDR_CLKIN_CTRL, 8'h00);
    wr(`SCC_ADDR_SYSREF_CTRL, 8'h00);
    pulse(lat, cnt);
    check(cnt, 0, "event while off");
    wr(`SCC_ADDR_SYSREF_CTRL, 8'h20);
    pulse(lat, cnt);
    check(cnt, 0, "event without processor");
    wr(`SCC_ADDR_SYSREF_CTRL, 8'h60);
    pulse(lat0, cnt);
    check(cnt, 1, "event count");
    if (lat0 < 0)
      conclude();
    for (int i = 0; i < 4; i++)
    begin
      d = (i == 0) ? 8'h0F : 8'($urandom_range(14, 1));
      wr(`SCC_ADDR_SYSREF_CTRL, 8'h60 | d);
      pulse(lat, cnt);
      check(lat - lat0, d, "delay step");
    end
    // Clock enable low must freeze the SYSREF path
    ce <= 1'b0;
    pulse(lat, cnt);
    check(cnt, 0, "event while frozen");
    ce <= 1'b1;
    for (int m = 0; m < 32; m++)
    begin
      wr(`SCC_ADDR_SYSREF_CTRL, {2'h0, m[4], 5'h00});
      wr(`SCC_ADDR_CLKIN_CTRL, {4'h0, m[0], 2'h0, m[2]});
      d = 8'($urandom());
      @(posedge ref_clk);
      timestamp_output_enable <= m[1];
      sysref_in <= m[3];
      sample_lsb_in <= d[0];
      repeat (3) @(posedge ref_clk);
      check(sample_lsb_out, (m[0] & m[1]) ? m[4] & (m[3] ^ m[2]) : d[0],
        "sample lsb");
      check(sysref_aligned, m[4] & (m[3] ^ m[2]), "aligned tap");
    end
    conclude();
  end
endmodule
